// File: shared/line_receive_channel_control_defs.vh
// constants for the twelve-channel receive path control bank
// Functional notes
// - two control registers per channel, addresses m5 and m6
// - analog loss detector off when bit4 set
// - analog disable honoured only in DS3/STS-1
// - bit3 picks recovered data launch edge
// - bit2 mutes both rails during loss defect
// - bit1 selects receive monitor mode
// - monitor mode suppresses all loss indication
// - bit0 enables receive equalizer
// - bit5 disables digital loss detector
`ifndef LINE_RECEIVE_CHANNEL_CONTROL_DEFS_VH
`define LINE_RECEIVE_CHANNEL_CONTROL_DEFS_VH
`define RPC_LOW_NIBBLE 4'h5
`define CMC_LOW_NIBBLE 4'h6
`define RPC_BIT_DIGITAL_SIGNAL_LOSS_DETECTOR_DIS 5
`define RPC_BIT_ANALOG_SIGNAL_LOSS_DETECTOR_DIS 4
`define RPC_BIT_CLK_INV 3
`define RPC_BIT_MUTE 2
`define RPC_BIT_MONITOR 1
`define RPC_BIT_EQ_EN 0
`define RPC_WRITE_MASK 8'h3f
`define RPC_RESET 8'h00
`define CMC_RESET 8'h00
`define CMC_WRITE_MASK 8'h3f
`define CMC_BIT_E3 2
`define CMC_BIT_STS1 1
`define NUM_CHANNELS 12
`endif

// File: verilog/line_receive_channel_control.v
// per-channel receive control registers and recovered data output stage
`timescale 1ns/1ps
`default_nettype none
`include "line_receive_channel_control_defs.vh"
module line_receive_channel_control #(
  parameter N = `NUM_CHANNELS
) (
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  input wire [N-1:0] recovered_clock_pin_i,
  input wire [N-1:0] rx_pos_data_i,
  input wire [N-1:0] rx_neg_data_i,
  input wire [N-1:0] analog_loss_raw_i,
  input wire [N-1:0] digital_loss_raw_i,
  output reg [N-1:0] recovered_positive_rail_out_o,
  output reg [N-1:0] recovered_negative_rail_out_o,
  output wire [N-1:0] signal_loss_defect_o,
  output wire [N-1:0] equalizer_enable_o,
  output wire [N-1:0] monitor_mode_o,
  output wire [N-1:0] european_rate_select_o
);
  // ----------------------------------------
  // address decode
  // ----------------------------------------
  // channel map skips m=6,7: valid high nibbles 0-5 and 8-d
  reg [3:0] chan;
  reg chan_ok;
  always @* begin
    chan_ok = 1'b1;
    if (addr_i[7:4] <= 4'h5) begin
      chan = addr_i[7:4];
    end else if (addr_i[7:4] >= 4'h8 && addr_i[7:4] <= 4'hd) begin
      chan = addr_i[7:4] - 4'h2;
    end else begin
      chan = 4'h0;
      chan_ok = 1'b0;
    end
  end

  // a narrower build must not alias the upper channel codes
  wire chan_hit;
  assign chan_hit = chan_ok && (chan < N);

  wire sel_rpc;
  assign sel_rpc = chan_hit && (addr_i[3:0] == `RPC_LOW_NIBBLE);

  wire sel_cmc;
  assign sel_cmc = chan_hit && (addr_i[3:0] == `CMC_LOW_NIBBLE);

  // ----------------------------------------
  // write strobes
  // ----------------------------------------
  // one strobe per channel so the storage has a single writer
  reg [N-1:0] wr_rpc;
  reg [N-1:0] wr_cmc;
  integer j;
  always @* begin
    wr_rpc = {N{1'b0}};
    wr_cmc = {N{1'b0}};
    for (j = 0; j < N; j = j + 1) begin
      if (wr_i && sel_rpc && chan == j) begin
        wr_rpc[j] = 1'b1;
      end
      if (wr_i && sel_cmc && chan == j) begin
        wr_cmc[j] = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // register storage
  // ----------------------------------------
  reg [7:0] rpc [0:N-1];
  reg [7:0] cmc [0:N-1];
  integer i;
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      for (i = 0; i < N; i = i + 1) begin
        rpc[i] <= `RPC_RESET;
        cmc[i] <= `CMC_RESET;
      end
    end else begin
      for (i = 0; i < N; i = i + 1) begin
        if (wr_rpc[i]) begin
          rpc[i] <= wdata_i & `RPC_WRITE_MASK;
        end
        if (wr_cmc[i]) begin
          cmc[i] <= wdata_i & `CMC_WRITE_MASK;
        end
      end
    end
  end

  // ----------------------------------------
  // read port
  // ----------------------------------------
  // unmapped codes read zero, data holds between reads
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      if (sel_rpc) begin
        rdata_o <= rpc[chan] & `RPC_WRITE_MASK;
      end else if (sel_cmc) begin
        rdata_o <= cmc[chan] & `CMC_WRITE_MASK;
      end else begin
        rdata_o <= 8'h00;
      end
    end
  end

  // ----------------------------------------
  // per-channel logic
  // ----------------------------------------
  wire [N-1:0] launch_vec;
  wire [N-1:0] mute_vec;
  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : ch
      reg [1:0] clk_sync;
      reg [1:0] analog_signal_loss_detector_sync;
      reg [1:0] digital_signal_loss_detector_sync;
      reg clk_prev;

      // recovered clock is asynchronous: two flops before use
      always @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
          clk_sync <= 2'b00;
        end else begin
          clk_sync <= {clk_sync[0], recovered_clock_pin_i[g]};
        end
      end

      // raw detector flags come from the analog side
      always @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
          analog_signal_loss_detector_sync <= 2'b00;
        end else begin
          analog_signal_loss_detector_sync <= {analog_signal_loss_detector_sync[0], analog_loss_raw_i[g]};
        end
      end

      always @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
          digital_signal_loss_detector_sync <= 2'b00;
        end else begin
          digital_signal_loss_detector_sync <= {digital_signal_loss_detector_sync[0], digital_loss_raw_i[g]};
        end
      end

      // previous level for edge detect; reset matches idle low clock
      always @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
          clk_prev <= 1'b0;
        end else begin
          clk_prev <= clk_sync[1];
        end
      end

      wire is_e3;
      assign is_e3 = cmc[g][`CMC_BIT_E3];

      wire analog_signal_loss_detector_on;
      assign analog_signal_loss_detector_on = !(rpc[g][`RPC_BIT_ANALOG_SIGNAL_LOSS_DETECTOR_DIS] && !is_e3);

      wire digital_signal_loss_detector_on;
      assign digital_signal_loss_detector_on = !rpc[g][`RPC_BIT_DIGITAL_SIGNAL_LOSS_DETECTOR_DIS];

      wire raw_loss;
      assign raw_loss = (analog_signal_loss_detector_on && analog_signal_loss_detector_sync[1]) ||
        (digital_signal_loss_detector_on && digital_signal_loss_detector_sync[1]);

      wire loss;
      assign loss = !rpc[g][`RPC_BIT_MONITOR] && raw_loss;
      assign signal_loss_defect_o[g] = loss;

      assign monitor_mode_o[g] = rpc[g][`RPC_BIT_MONITOR];

      assign equalizer_enable_o[g] = rpc[g][`RPC_BIT_EQ_EN];

      assign european_rate_select_o[g] = is_e3;

      wire rise;
      assign rise = !clk_prev && clk_sync[1];
      wire fall;
      assign fall = clk_prev && !clk_sync[1];

      assign launch_vec[g] = rpc[g][`RPC_BIT_CLK_INV] ? fall : rise;

      assign mute_vec[g] = rpc[g][`RPC_BIT_MUTE] && loss;
    end
  endgenerate

  // ----------------------------------------
  // recovered data output stage
  // ----------------------------------------
  // edge seen about three clocks late; fine at link rates below fclk/6
  integer k;
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      recovered_positive_rail_out_o <= {N{1'b0}};
      recovered_negative_rail_out_o <= {N{1'b0}};
    end else begin
      for (k = 0; k < N; k = k + 1) begin
        if (mute_vec[k]) begin
          recovered_positive_rail_out_o[k] <= 1'b0;
          recovered_negative_rail_out_o[k] <= 1'b0;
        end else if (launch_vec[k]) begin
          recovered_positive_rail_out_o[k] <= rx_pos_data_i[k];
          recovered_negative_rail_out_o[k] <= rx_neg_data_i[k];
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: tb/lrcc_props.sv
// assertions on the receive control bank ports
`timescale 1ns/1ps
`default_nettype none
module lrcc_props #(parameter N=12)(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] rdata_o,
  input wire logic [N-1:0] analog_loss_raw_i,
  input wire logic [N-1:0] digital_loss_raw_i,
  input wire logic [N-1:0] signal_loss_defect_o,
  input wire logic [N-1:0] equalizer_enable_o,
  input wire logic [N-1:0] monitor_mode_o,
  input wire logic [N-1:0] european_rate_select_o
);
  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  sequence s_wr0;
    wr_i && addr_i == 8'h05;
  endsequence
  sequence s_rb;
    s_wr0 ##1 rd_i && !wr_i && addr_i == 8'h05;
  endsequence
  AST_RB: assert property (
    s_rb |=> rdata_o == {2'b00, $past(wdata_i[5:0], 2)})
    else $error("readback");
  AST_RSV: assert property (rd_i |=> rdata_o[7:6] == 2'b00)
    else $error("reserved");
  AST_EQ: assert property (
    s_wr0 |=> equalizer_enable_o[0] == $past(wdata_i[0]))
    else $error("eq");
  AST_MON: assert property (
    s_wr0 |=> monitor_mode_o[0] == $past(wdata_i[1]))
    else $error("monitor");
  AST_CH11: assert property (
    wr_i && addr_i == 8'hd5 |=>
      equalizer_enable_o[N-1] == $past(wdata_i[0]))
    else $error("ch11");
  AST_UNM: assert property (
    rd_i && addr_i == 8'h67 |=> rdata_o == 8'h00)
    else $error("unmapped");
  AST_E3: assert property (
    wr_i && addr_i == 8'h06 |=>
      european_rate_select_o[0] == $past(wdata_i[2]))
    else $error("rate");
  AST_SUP: assert property (
    (monitor_mode_o & signal_loss_defect_o) == 0)
    else $error("suppress");
  AST_QUIET: assert property (
    (analog_loss_raw_i == 0 && digital_loss_raw_i == 0)[*4] |->
      signal_loss_defect_o == 0)
    else $error("quiet");
endmodule
bind line_receive_channel_control lrcc_props #(.N(N)) u_props(.*);
`default_nettype wire

// File: tb/rail_sink.sv
// framer side sink counting clocks with a mark on either channel 0 rail
`timescale 1ns/1ps
`default_nettype none
module rail_sink #(parameter N=12)(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [N-1:0] pos_i,
  input wire logic [N-1:0] neg_i,
  output logic [15:0] ones_o
);
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      ones_o <= 16'h0000;
    end else begin
      ones_o <= ones_o + 16'(pos_i[0] | neg_i[0]);
    end
  end
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// bench for the receive control bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk=0, rst_n=0, wr=0, rd=0, lck=0;
  logic [7:0] a=0, d=0, q;
  logic [11:0] al=0, dl=0, signal_loss_defect, p, n;
  logic [15:0] k, k0;
  int err_count=0, samples_checked=0, cyc=0;
  always #4 clk = ~clk;
  // link clock runs at one tenth of the sys clock rate
  always #40 lck = ~lck;
  // rails follow the link clock, so the captured level shows the edge
  line_receive_channel_control i_dut(.sys_clk_i(clk), .rst_n_i(rst_n),
    .addr_i(a), .wdata_i(d), .wr_i(wr), .rd_i(rd), .rdata_o(q),
    .recovered_clock_pin_i({12{lck}}), .rx_pos_data_i({12{lck}}),
    .rx_neg_data_i({12{~lck}}), .analog_loss_raw_i(al),
    .digital_loss_raw_i(dl), .recovered_positive_rail_out_o(p),
    .recovered_negative_rail_out_o(n), .signal_loss_defect_o(signal_loss_defect),
    .equalizer_enable_o(), .monitor_mode_o(), .european_rate_select_o());
  rail_sink i_sink(.clk_i(clk), .rst_n_i(rst_n), .pos_i(p), .neg_i(n),
    .ones_o(k));
  task chk(input [15:0] g, e);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %0t got %h", $time, g);
    end
  endtask
  // strobes held between calls, never set twice per step
  task w(input [7:0] x, y);
    a = x;
    d = y;
    wr = 1;
    rd = 0;
    @(negedge clk);
  endtask
  task r(input [7:0] x, e);
    a = x;
    rd = 1;
    wr = 0;
    @(negedge clk);
    chk(q, e);
  endtask
  task s(input l);
    wr=0; rd=0;
    repeat (20) @(negedge clk);
    k0=k;
    repeat (20) @(negedge clk);
    chk(signal_loss_defect[0], l);
    $display("test done");
  endtask
  task conclude;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count==0 && samples_checked>0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    if (++cyc == 3000) begin
      err_count++;
      conclude;
    end
  end
  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1;
    @(negedge clk);
    r(8'h05, 8'h00);
    w(8'h85, 8'hff);
    r(8'h85, 8'h3f);
    w(8'hd5, 8'h01);
    r(8'h67, 8'h00);
    r(8'hd5, 8'h01);
    w(8'h05, 8'h05);
    r(8'h05, 8'h05);
    al = 1;
    s(1);
    chk(k, k0);
    w(8'h05, 8'h01);
    s(1);
    chk(k == k0, 0);
    chk(p[0], 1);
    chk(n[0], 0);
    w(8'h05, 8'h09);
    s(1);
    chk(p[0], 0);
    chk(n[0], 1);
    w(8'h05, 8'h02);
    s(0);
    w(8'h05, 8'h10);
    s(0);
    w(8'h06, 8'h04);
    w(8'h05, 8'h10);
    s(1);
    al = 0;
    dl = 1;
    w(8'h05, 8'h20);
    s(0);
    w(8'h05, 8'h00);
    s(1);
    conclude;
  end
endmodule
`default_nettype wire
